/* File: pkg/meb_pkg.sv */
// Purpose: Shared constants and types for the multiplexed external memory bus.
// Assumes: One 20 MHz clock; port B bit positions fixed by the pinout.
// Notes:   Counts are in clk cycles.
package meb_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ       = 20_000_000;
	localparam int STROBE_CYC   = 2;
	localparam int SYNC_STAGES  = 2;

	// ----------------------------------------------------------------
	// Port B pin positions
	// ----------------------------------------------------------------
	localparam int PB_HOLD_ACK  = 7;
	localparam int PB_BANK0     = 8;
	localparam int PB_BANK1     = 9;
	localparam int PB_LATCH     = 10;
	localparam int PB_WRITE     = 11;
	localparam int PB_HIGH_BYTE = 12;
	localparam int PB_BANK2     = 13;
	localparam int PB_BANK3     = 14;
	localparam int PB_READ      = 15;

	// ----------------------------------------------------------------
	// Status word field and reset values
	// ----------------------------------------------------------------
	localparam int          PSW_WAIT_LSB = 3;
	localparam logic [15:0] AD_RESET     = 16'h0000;
	localparam logic [3:0]  BANK_RESET   = 4'h0;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_ADDR   = 3'b001,
		ST_STROBE = 3'b010,
		ST_END    = 3'b011,
		ST_FLOAT  = 3'b100,
		ST_HOLD   = 3'b101,
		ST_RESUME = 3'b110
	} meb_state_t;

endpackage

/* File: hw/meb_sync.sv */
// Purpose: Two-flop synchroniser for a group of pin inputs.
// Assumes: Each bit is independent; no word coherence is implied.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/1ps
module meb_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	import meb_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} meb_sync_st_t;

	meb_sync_st_t s_r;
	meb_sync_st_t s_nxt;

	initial begin
		if (WIDTH < 1) begin
			$error("meb_sync: WIDTH must be at least 1");
		end
	end

	always_comb begin
		s_nxt.meta   = async_in;
		s_nxt.stable = s_r.meta;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sync_out = s_r.stable;
endmodule

/* File: hw/meb_bus_if.sv */
// Purpose: Multiplexed address/data bus master with port B control pins.
// Assumes: Core requests come from logic on clk; pins are asynchronous.
// Notes:   Every pin output and enable is registered.
`timescale 1ns/1ps

module meb_bus_if #(
	parameter int DATA_W = 16
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire logic        req_write,
	input  wire logic        req_word,
	input  wire logic        req_fetch_first,
	input  wire logic [15:0] req_addr,
	input  wire logic [15:0] req_wdata,
	input  wire logic [3:0]  req_bank,
	output logic             rsp_valid,
	output logic      [15:0] rsp_rdata,
	input  wire logic [15:0] processor_status_word,
	input  wire logic        ready_hold_sel,
	input  wire logic        ext_addr_mode,
	input  wire logic        state_skip_or_int,
	input  wire logic [15:0] portb_function_select,
	input  wire logic [15:0] portb_gpio_out,
	input  wire logic [15:0] portb_gpio_oe,
	input  wire logic [15:0] portb_alt_out,
	input  wire logic [15:0] portb_alt_oe,
	output logic      [15:0] portb_gpio_in,
	input  wire logic [15:0] ad_in,
	output logic      [15:0] ad_out,
	output logic             ad_oe,
	input  wire logic [15:0] portb_in,
	output logic      [15:0] portb_out,
	output logic      [15:0] portb_oe,
	input  wire logic        ready_or_hold_in,
	output logic             fetch_status_out,
	output logic             state_status_out,
	output logic             half_rate_clock_out,
	output logic             inverted_clock_out
);
	import meb_pkg::*;

	initial begin
		if (DATA_W != 16) begin
			$error("meb_bus_if: the multiplexed port is exactly 16 bits wide");
		end
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		meb_state_t  st;
		logic [2:0]  cnt;
		logic        write;
		logic        req_ready;
		logic        rsp_valid;
		logic [15:0] rdata;
		logic [15:0] ad_out;
		logic        ad_oe;
		logic        latch;
		logic        read_n;
		logic        write_n;
		logic        high_byte_enable_n;
		logic        ctl_oe;
		logic        hold_ack_n;
		logic [3:0]  bank;
		logic        fetch;
		logic        skip_int;
		logic        half_clk;
		logic        inv_clk;
		logic [15:0] pb_out;
		logic [15:0] pb_oe;
	} meb_bus_st_t;

	meb_bus_st_t s_r;
	meb_bus_st_t s_nxt;

	logic [32:0] pins_sync;
	logic        ready_hold_s;
	logic [15:0] ad_s;
	logic [15:0] pb_s;
	logic        hold_req;
	logic        ready_ok;
	logic [1:0]  wait_sel;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	meb_sync #(
		.WIDTH(33)
	) u_sync (
		.clk     (clk),
		.resetn  (resetn),
		.async_in({ready_or_hold_in, ad_in, portb_in}),
		.sync_out(pins_sync)
	);

	assign ready_hold_s = pins_sync[32];
	assign ad_s         = pins_sync[31:16];
	assign pb_s         = pins_sync[15:0];

	// Pin low means hold request in hold use, not ready in ready use.
	assign hold_req = ready_hold_sel & ~ready_hold_s;
	assign ready_ok = ready_hold_sel | ready_hold_s;
	assign wait_sel = processor_status_word[PSW_WAIT_LSB +: 2];

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt           = s_r;
		s_nxt.rsp_valid = 1'b0;
		s_nxt.half_clk  = ~s_r.half_clk;
		s_nxt.inv_clk   = s_r.half_clk;
		s_nxt.skip_int  = state_skip_or_int;

		case (s_r.st)
			ST_IDLE: begin
				s_nxt.ad_oe  = 1'b0;
				s_nxt.fetch  = 1'b0;
				s_nxt.ctl_oe = 1'b1;
				s_nxt.latch  = 1'b0;
				// Hold is only entered from here, so a cycle is never cut short.
				if (hold_req) begin
					s_nxt.st        = ST_FLOAT;
					s_nxt.ctl_oe    = 1'b0;
					s_nxt.req_ready = 1'b0;
				end else if (req_valid && s_r.req_ready) begin
					s_nxt.st                 = ST_ADDR;
					s_nxt.req_ready          = 1'b0;
					s_nxt.write              = req_write;
					s_nxt.ad_out             = req_addr;
					s_nxt.ad_oe              = 1'b1;
					s_nxt.latch              = 1'b1;
					s_nxt.high_byte_enable_n = ~(req_word | req_addr[0]);
					s_nxt.bank               = req_bank;
					s_nxt.fetch              = req_fetch_first;
					if (req_word || !req_addr[0]) begin
						s_nxt.rdata = req_wdata;
					end else begin
						s_nxt.rdata = {req_wdata[7:0], req_wdata[7:0]};
					end
				end else begin
					s_nxt.req_ready = 1'b1;
				end
			end
			ST_ADDR: begin
				s_nxt.st    = ST_STROBE;
				s_nxt.latch = 1'b0;
				// The count is loaded once, so a status word change mid-cycle cannot alter it.
				s_nxt.cnt   = 3'(STROBE_CYC - 1) + {1'b0, wait_sel};
				if (s_r.write) begin
					s_nxt.write_n = 1'b0;
					s_nxt.ad_out  = s_r.rdata;
				end else begin
					s_nxt.read_n = 1'b0;
					s_nxt.ad_oe  = 1'b0;
				end
			end
			ST_STROBE: begin
				// Ready is only heard after the wait states, so it lengthens a cycle but never cuts it.
				if (s_r.cnt != 3'd0) begin
					s_nxt.cnt = s_r.cnt - 3'd1;
				end else if (ready_ok) begin
					s_nxt.st        = ST_END;
					s_nxt.read_n    = 1'b1;
					s_nxt.write_n   = 1'b1;
					s_nxt.rsp_valid = 1'b1;
					if (!s_r.write) begin
						s_nxt.rdata = ad_s;
					end
				end
			end
			ST_END: begin
				// Write data and byte lanes stay one more cycle as hold time.
				s_nxt.st                 = ST_IDLE;
				s_nxt.ad_oe              = 1'b0;
				s_nxt.fetch              = 1'b0;
				s_nxt.high_byte_enable_n = 1'b1;
				s_nxt.req_ready          = ~hold_req;
			end
			ST_FLOAT: begin
				s_nxt.st         = ST_HOLD;
				s_nxt.hold_ack_n = 1'b0;
			end
			ST_HOLD: begin
				if (!hold_req) begin
					s_nxt.st         = ST_RESUME;
					s_nxt.hold_ack_n = 1'b1;
				end
			end
			ST_RESUME: begin
				s_nxt.st        = ST_IDLE;
				s_nxt.ctl_oe    = 1'b1;
				s_nxt.req_ready = 1'b1;
			end
			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase

		// Port B pin by pin: general I/O unless the function bit is set, or ext_addr_mode is set for the bank pins.
		for (int b = 0; b < 16; b++) begin
			if (portb_function_select[b]) begin
				s_nxt.pb_out[b] = portb_alt_out[b];
				s_nxt.pb_oe[b]  = portb_alt_oe[b];
			end else begin
				s_nxt.pb_out[b] = portb_gpio_out[b];
				s_nxt.pb_oe[b]  = portb_gpio_oe[b];
			end
		end
		if (portb_function_select[PB_LATCH]) begin
			s_nxt.pb_out[PB_LATCH] = s_nxt.latch;
			s_nxt.pb_oe[PB_LATCH]  = s_nxt.ctl_oe;
		end
		if (portb_function_select[PB_WRITE]) begin
			s_nxt.pb_out[PB_WRITE] = s_nxt.write_n;
			s_nxt.pb_oe[PB_WRITE]  = s_nxt.ctl_oe;
		end
		if (portb_function_select[PB_HIGH_BYTE]) begin
			s_nxt.pb_out[PB_HIGH_BYTE] = s_nxt.high_byte_enable_n;
			s_nxt.pb_oe[PB_HIGH_BYTE]  = s_nxt.ctl_oe;
		end
		if (portb_function_select[PB_READ]) begin
			s_nxt.pb_out[PB_READ] = s_nxt.read_n;
			s_nxt.pb_oe[PB_READ]  = s_nxt.ctl_oe;
		end
		if (portb_function_select[PB_HOLD_ACK]) begin
			s_nxt.pb_out[PB_HOLD_ACK] = s_nxt.hold_ack_n;
			s_nxt.pb_oe[PB_HOLD_ACK]  = 1'b1;
		end
		// The bank number rides on the bus enable so it floats during hold.
		if (ext_addr_mode) begin
			s_nxt.pb_out[PB_BANK0] = s_nxt.bank[0];
			s_nxt.pb_out[PB_BANK1] = s_nxt.bank[1];
			s_nxt.pb_out[PB_BANK2] = s_nxt.bank[2];
			s_nxt.pb_out[PB_BANK3] = s_nxt.bank[3];
			s_nxt.pb_oe[PB_BANK0]  = s_nxt.ctl_oe;
			s_nxt.pb_oe[PB_BANK1]  = s_nxt.ctl_oe;
			s_nxt.pb_oe[PB_BANK2]  = s_nxt.ctl_oe;
			s_nxt.pb_oe[PB_BANK3]  = s_nxt.ctl_oe;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_r                    <= '0;
			s_r.st                 <= ST_IDLE;
			s_r.ad_out             <= AD_RESET;
			s_r.bank               <= BANK_RESET;
			s_r.read_n             <= 1'b1;
			s_r.write_n            <= 1'b1;
			s_r.high_byte_enable_n <= 1'b1;
			s_r.hold_ack_n         <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign req_ready           = s_r.req_ready;
	assign rsp_valid           = s_r.rsp_valid;
	assign rsp_rdata           = s_r.rdata;
	assign ad_out              = s_r.ad_out;
	assign ad_oe               = s_r.ad_oe;
	assign portb_out           = s_r.pb_out;
	assign portb_oe            = s_r.pb_oe;
	assign portb_gpio_in       = pb_s;
	assign fetch_status_out    = s_r.fetch;
	assign state_status_out    = s_r.skip_int;
	assign half_rate_clock_out = s_r.half_clk;
	assign inverted_clock_out  = s_r.inv_clk;
endmodule

/* File: verification/meb_checker.sv */
// Purpose: Port assertions for the multiplexed external memory bus block.
// Assumes: Strobe pins are read with their alternate function selected.
// Notes:   Bound into every instance of the bus block.
`timescale 1ns/1ps
module meb_checker (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        req_fetch_first,
	input wire logic        state_skip_or_int,
	input wire logic        ad_oe,
	input wire logic [15:0] portb_out,
	input wire logic [15:0] portb_oe,
	input wire logic        fetch_status_out,
	input wire logic        state_status_out,
	input wire logic        half_rate_clock_out,
	input wire logic        inverted_clock_out
);
	import meb_pkg::*;
	wire latch = portb_out[PB_LATCH];
	wire rd_n  = portb_out[PB_READ];
	wire wr_n  = portb_out[PB_WRITE];
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// ----------------------------------------------------------------
	// Bus cycle phases
	// ----------------------------------------------------------------
	sequence s_addr;
		$rose(latch) && ad_oe;
	endsequence
	sequence s_strobe;
		!latch && (rd_n != wr_n);
	endsequence
	property p_phase; s_addr |=> s_strobe; endproperty
	property p_excl; $past(resetn) |-> rd_n || wr_n; endproperty
	property p_rd_float; !rd_n |-> !ad_oe; endproperty
	property p_rd_min; $fell(rd_n) |-> !rd_n [*2]; endproperty
	property p_lanes; !(rd_n && wr_n) |-> $stable(portb_out[PB_HIGH_BYTE]); endproperty
	property p_fetch; $rose(latch) |-> fetch_status_out == $past(req_fetch_first); endproperty
	property p_state; $past(resetn) |-> state_status_out == $past(state_skip_or_int); endproperty
	property p_div; $past(resetn) |-> half_rate_clock_out != $past(half_rate_clock_out); endproperty
	property p_inv; $past(resetn) |-> inverted_clock_out != half_rate_clock_out; endproperty
	property p_hold;
		$fell(portb_out[PB_HOLD_ACK]) |-> !ad_oe && !$past(ad_oe) &&
			!portb_oe[PB_READ] && !$past(portb_oe[PB_READ]);
	endproperty
	// Sampled on the falling edge so the first reset edge has settled the pins.
	property p_rst;
		@(negedge clk) disable iff (1'b0) !resetn |-> !ad_oe && portb_oe == 16'h0000;
	endproperty
	a_phase: assert property (p_phase) else $error("latch not followed by one strobe");
	a_excl: assert property (p_excl) else $error("both strobes low");
	a_rd_float: assert property (p_rd_float) else $error("bus driven in read");
	a_rd_min: assert property (p_rd_min) else $error("read strobe too short");
	a_lanes: assert property (p_lanes) else $error("byte enable moved in strobe");
	a_fetch: assert property (p_fetch) else $error("fetch status wrong");
	a_state: assert property (p_state) else $error("state status wrong");
	a_div: assert property (p_div) else $error("half rate clock stuck");
	a_inv: assert property (p_inv) else $error("clock not inverted");
	a_hold: assert property (p_hold) else $error("ack before bus float");
	a_rst: assert property (p_rst) else $error("pins driven in reset");
endmodule

bind meb_bus_if meb_checker chk_u (
	.clk, .resetn, .req_fetch_first, .state_skip_or_int, .ad_oe, .portb_out,
	.portb_oe, .fetch_status_out, .state_status_out, .half_rate_clock_out,
	.inverted_clock_out
);

/* File: verification/meb_mem.sv */
// Purpose: Behavioural external memory behind a transparent address latch.
// Assumes: Sixteen words; address bits above 4 are ignored.
// Notes:   A released bus shows the inverse of its last value.
`timescale 1ns/1ps
module meb_mem (
	input  wire logic        clk,
	input  wire logic [15:0] ad_out,
	input  wire logic [15:0] portb_out,
	output logic      [15:0] ad_in
);
	import meb_pkg::*;
	logic [15:0] mem [16];
	logic [15:0] addr_r = 16'h0000;
	logic [15:0] last_r = 16'h0000;
	logic [15:0] addr;
	logic        drive;
	// The latch is transparent, so data is ready while the strobe is still high.
	assign addr  = portb_out[PB_LATCH] ? ad_out : addr_r;
	assign drive = portb_out[PB_WRITE] && (portb_out[PB_LATCH] || !portb_out[PB_READ]);
	assign ad_in = drive ? mem[addr[4:1]] : ~last_r;
	always @(posedge clk) begin
		last_r <= ad_in;
		if (portb_out[PB_LATCH])
			addr_r <= ad_out;
		if (!portb_out[PB_WRITE] && !portb_out[PB_HIGH_BYTE])
			mem[addr_r[4:1]][15:8] <= ad_out[15:8];
		if (!portb_out[PB_WRITE] && !addr_r[0])
			mem[addr_r[4:1]][7:0] <= ad_out[7:0];
	end
endmodule

/* File: verification/mux_external_memory_bus_tb.sv */
// Purpose: Self-checking bench for the external memory bus block.
// Assumes: Bus control pins use their alternate function.
// Notes:   Cycle counts are taken from the take edge to the response.
`timescale 1ns/1ps
module mux_external_memory_bus_tb;
	import meb_pkg::*;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        req_valid, req_write, req_word, req_fetch_first, ready_hold_sel;
	logic        ext_addr_mode, state_skip_or_int, ready_or_hold_in;
	logic        req_ready, rsp_valid, ad_oe, fetch_status_out, state_status_out;
	logic        half_rate_clock_out, inverted_clock_out;
	logic [15:0] req_addr, req_wdata, processor_status_word, portb_function_select;
	logic [15:0] portb_gpio_out, portb_gpio_oe, portb_alt_out, portb_alt_oe, portb_in;
	logic [15:0] rsp_rdata, portb_gpio_in, ad_in, ad_out, portb_out, portb_oe, rd;
	logic [3:0]  req_bank;
	int          fail_count = 0;
	int          checked = 0;
	int          cyc = 0;
	int          n;
	meb_bus_if dut_u (
		.clk, .resetn, .req_valid, .req_ready, .req_write, .req_word, .req_fetch_first,
		.req_addr, .req_wdata, .req_bank, .rsp_valid, .rsp_rdata, .processor_status_word,
		.ready_hold_sel, .ext_addr_mode, .state_skip_or_int, .portb_function_select,
		.portb_gpio_out, .portb_gpio_oe, .portb_alt_out, .portb_alt_oe, .portb_gpio_in,
		.ad_in, .ad_out, .ad_oe, .portb_in, .portb_out, .portb_oe, .ready_or_hold_in,
		.fetch_status_out, .state_status_out, .half_rate_clock_out, .inverted_clock_out
	);
	meb_mem mem_u (.clk, .ad_out, .portb_out, .ad_in);
	initial forever #25 clk = ~clk;
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic acc(input logic w, wd, f, input logic [15:0] a, d);
		req_valid <= 1'b1;
		req_write <= w;
		req_word <= wd;
		req_fetch_first <= f;
		req_addr <= a;
		req_wdata <= d;
		@(posedge clk);
		while (req_ready !== 1'b1) @(posedge clk);
		req_valid <= 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1) begin
			@(posedge clk);
			n++;
		end
		rd = rsp_rdata;
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	initial begin
		{req_valid, req_write, req_word, req_fetch_first, ready_hold_sel} = '0;
		{ext_addr_mode, state_skip_or_int, req_bank, req_addr, req_wdata} = '0;
		ready_or_hold_in = 1'b1;
		processor_status_word = 16'h0000;
		portb_function_select = 16'h9C80;
		{portb_gpio_out, portb_alt_out} = {16'h0001, 16'h0003};
		{portb_gpio_oe, portb_alt_oe, portb_in} = {16'hFFFF, 16'hFFFF, 16'hA5C3};
		repeat (3) @(posedge clk);
		chk("reset portb oe", portb_oe, 16'h0000);
		chk("reset ad oe", 16'(ad_oe), 16'h0000);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		chk("gpio pins", 16'(portb_out[1:0]), 16'h0001);
		acc(1'b1, 1'b1, 1'b0, 16'h0004, 16'h1234);
		acc(1'b0, 1'b1, 1'b1, 16'h0004, 16'h0000);
		chk("word", rd, 16'h1234);
		acc(1'b1, 1'b0, 1'b0, 16'h0007, 16'h00AB);
		acc(1'b1, 1'b0, 1'b0, 16'h0006, 16'h00CD);
		acc(1'b0, 1'b1, 1'b0, 16'h0006, 16'h0000);
		chk("bytes", rd, 16'hABCD);
		acc(1'b0, 1'b0, 1'b0, 16'h0007, 16'h0000);
		chk("odd byte", 16'(rd[15:8]), 16'h00AB);
		$display("test bytes done");
		for (int ws = 0; ws < 4; ws++) begin
			processor_status_word <= 16'(ws << PSW_WAIT_LSB);
			@(posedge clk);
			acc(1'b0, 1'b1, 1'b0, 16'h0004, 16'h0000);
			chk("cycles", 16'(n), 16'(4 + ws));
		end
		$display("test waits done");
		processor_status_word <= 16'h0000;
		ready_or_hold_in <= 1'b0;
		fork
			acc(1'b0, 1'b1, 1'b0, 16'h0004, 16'h0000);
			begin
				repeat (12) @(posedge clk);
				ready_or_hold_in <= 1'b1;
			end
		join
		chk("stretch", 16'(n > 12), 16'h0001);
		chk("slow data", rd, 16'h1234);
		$display("test ready done");
		ready_hold_sel <= 1'b1;
		repeat (3) @(posedge clk);
		ready_or_hold_in <= 1'b0;
		n = 0;
		while (portb_out[PB_HOLD_ACK] !== 1'b0 && n < 20) begin
			@(posedge clk);
			n++;
		end
		chk("hold", 16'({ad_oe, req_ready, portb_out[PB_HOLD_ACK]}), 16'h0000);
		chk("hold pins", portb_oe, 16'h63FF);
		ready_or_hold_in <= 1'b1;
		n = 0;
		while (req_ready !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		chk("hold release", 16'(portb_out[PB_HOLD_ACK]), 16'h0001);
		ready_hold_sel <= 1'b0;
		$display("test hold done");
		ext_addr_mode <= 1'b1;
		req_bank <= 4'h9;
		state_skip_or_int <= 1'b1;
		portb_function_select[1:0] <= 2'b11;
		acc(1'b0, 1'b1, 1'b0, 16'h0004, 16'h0000);
		chk("bank", 16'({portb_out[14:13], portb_out[9:8]}), 16'h0009);
		chk("alt pins", 16'(portb_out[1:0]), 16'h0003);
		chk("gpio in", portb_gpio_in, 16'hA5C3);
		chk("state status", 16'(state_status_out), 16'h0001);
		$display("test pins done");
		tally_and_finish();
	end
endmodule
